// >>> adcseq_checker.sv
`timescale 1ns/1ns
`include "adcseq_consts.svh"
module adcseq_checker (
	// clock and reset
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	// register port
	input wire adcseq_pkg::adcseq_bus_t bus_i,
	input wire logic [31:0]             rdata_o,
	// flags and pulses
	input wire logic                    global_ie_i,
	input wire logic                    irq_o,
	input wire logic                    ev_result_o,
	input wire logic                    conv_clk_en_o,
	input wire logic                    hold_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// software clears of the ready flag
	sequence s_rd_res;
		bus_i.rd && bus_i.addr == `ADCSEQ_A_RESULT;
	endsequence
	sequence s_w1c;
		bus_i.wr && bus_i.addr == `ADCSEQ_A_FLAGS && bus_i.wdata[0];
	endsequence

	////////////////////////////////////////////////////////////////
	// a completion in the clearing cycle wins, hence the escape on ev_result_o
	a_irq_global: assert property (irq_o |-> global_ie_i)
		else $error("irq raised without global enable");
	a_ev_pulse: assert property (ev_result_o |=> !ev_result_o)
		else $error("result event longer than one cycle");
	a_done_tick: assert property (ev_result_o |-> $past(conv_clk_en_o))
		else $error("result not right after a conversion tick");
	a_tick_pulse: assert property (conv_clk_en_o |=> !conv_clk_en_o)
		else $error("conversion tick on two cycles in a row");
	a_hold_pulse: assert property (hold_o |=> !hold_o)
		else $error("hold pulse longer than one cycle");
	a_read_clears: assert property (s_rd_res |=> !irq_o || ev_result_o)
		else $error("result read left the flag set");
	a_w1c_clears: assert property (s_w1c |=> !irq_o || ev_result_o)
		else $error("flag write left the flag set");
	a_res_width: assert property (s_rd_res |=> rdata_o[31:10] == 22'h0)
		else $error("result not right adjusted");
endmodule

bind adcseq_top adcseq_checker i_adcseq_checker (.clk_i, .rst_i, .bus_i, .rdata_o, .global_ie_i, .irq_o,
	.ev_result_o, .conv_clk_en_o, .hold_o);

// >>> adcseq_consts.svh
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH

// register addresses (word index = address)
`define ADCSEQ_A_CTRL    4'h0
`define ADCSEQ_A_CMD     4'h1
`define ADCSEQ_A_FLAGS   4'h2
`define ADCSEQ_A_INTEN   4'h3
`define ADCSEQ_A_SEL     4'h4
`define ADCSEQ_A_SAMP    4'h5
`define ADCSEQ_A_RESULT  4'h6
`define ADCSEQ_A_STATUS  4'h7

// field positions
`define ADCSEQ_B_ENABLE  0
`define ADCSEQ_B_FREE_RUNNING_SELECT 1
`define ADCSEQ_B_EVSTART 2
`define ADCSEQ_B_START   0
`define ADCSEQ_B_RDY     0

// timing in conversion clock cycles
`define ADCSEQ_CONV_CYC  5'h0d
`define ADCSEQ_HOLD_CYC  5'h02

`endif

// >>> adcseq_core_model.sv
`timescale 1ns/1ns
module adcseq_core_model (
	// clock
	input wire logic                    clk_i,
	// from the sequencer
	input wire adcseq_pkg::adcseq_sel_t sel_o,
	input wire logic                    hold_o,
	// to the sequencer
	output logic [9:0]                  core_result_o = 10'h0
);
	// capture only at hold, so a later channel change cannot leak into the result
	always @(posedge clk_i) begin
		if (hold_o) begin
			core_result_o <= {5'h15, sel_o.chan};
		end
	end
endmodule

// >>> adcseq_pkg.sv
package adcseq_pkg;
	// register bus request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} adcseq_bus_t;

	// selections passed to the analog core
	typedef struct packed {
		logic [4:0] chan;
		logic [1:0] ref_sel;
	} adcseq_sel_t;

	typedef enum logic [1:0] {
		ADCSEQ_IDLE,
		ADCSEQ_ARM,
		ADCSEQ_CONV
	} adcseq_state_t;
endpackage

// >>> adcseq_top.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "adcseq_consts.svh"
module adcseq_top (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// register port
	input  wire adcseq_pkg::adcseq_bus_t bus_i,
	output logic [31:0]               rdata_o,
	// events and system
	input  wire logic                 ev_start_i,
	input  wire logic                 global_ie_i,
	output logic                      irq_o,
	output logic                      ev_result_o,
	// analog core
	input  wire logic [9:0]           core_result_i,
	output adcseq_pkg::adcseq_sel_t   sel_o,
	output logic                      conv_clk_en_o,
	output logic                      hold_o
);

////////////////////////////////////////////////////////////////////////
// registers and next values
logic                      enable, free_run, ev_en, start_cmd, rdy, ie;
logic                      next_enable, next_free_run, next_ev_en, next_start_cmd, next_rdy, next_ie;
adcseq_pkg::adcseq_sel_t   shadow, next_shadow, active, next_active;
logic [2:0]                clock_divider_select, next_clock_divider_select;
logic [7:0]                samp_dly, samp_len, next_samp_dly, next_samp_len;
logic [9:0]                result, next_result;
logic [31:0]               next_rdata;
adcseq_pkg::adcseq_state_t state, next_state;
logic [8:0]                div_cnt, next_div_cnt;
logic [9:0]                cyc, next_cyc;
logic                      ev_q, next_ev_q;
logic                      next_ev_result, next_hold;

// divider terminal count: factor 2^(clock_divider_select+1)
function automatic logic [8:0] div_last(input logic [2:0] p);
	// shift amount widened so the largest factor does not wrap to one
	div_last = 9'(({1'b0, 8'h01} << (4'(p) + 4'h1)) - 9'h001);
endfunction

function automatic logic wr_at(input adcseq_pkg::adcseq_bus_t b, input logic [3:0] a);
	wr_at = b.wr && (b.addr == a);
endfunction

logic       tick;
logic [9:0] total;
logic       ev_edge, sw_start, trig, done;

////////////////////////////////////////////////////////////////////////
// derived combinational terms
always_comb begin
	tick     = (state == adcseq_pkg::ADCSEQ_CONV || state == adcseq_pkg::ADCSEQ_ARM)
	           && div_cnt == div_last(clock_divider_select);
	total    = 10'(`ADCSEQ_CONV_CYC) + 10'(samp_dly) + 10'(samp_len);
	ev_edge  = ev_start_i && !ev_q;
	sw_start = wr_at(bus_i, `ADCSEQ_A_CMD) && bus_i.wdata[`ADCSEQ_B_START];
	trig     = enable && !start_cmd && (sw_start || (ev_en && ev_edge));
	done     = state == adcseq_pkg::ADCSEQ_CONV && tick && cyc == total - 10'h001;
end

////////////////////////////////////////////////////////////////////////
// next state of control, registers and sequencer
always_comb begin
	next_enable    = enable;
	next_free_run  = free_run;
	next_ev_en     = ev_en;
	next_start_cmd = start_cmd;
	next_rdy       = rdy;
	next_ie        = ie;
	next_shadow    = shadow;
	next_active    = active;
	next_clock_divider_select     = clock_divider_select;
	next_samp_dly  = samp_dly;
	next_samp_len  = samp_len;
	next_result    = result;
	next_state     = state;
	next_div_cnt   = div_cnt;
	next_cyc       = cyc;
	next_ev_q      = ev_start_i;
	next_ev_result = 1'b0;
	next_hold      = 1'b0;
	next_rdata     = 32'h0;
	// register writes
	if (wr_at(bus_i, `ADCSEQ_A_CTRL)) begin
		next_enable   = bus_i.wdata[`ADCSEQ_B_ENABLE];
		next_free_run = bus_i.wdata[`ADCSEQ_B_FREE_RUNNING_SELECT];
		next_ev_en    = bus_i.wdata[`ADCSEQ_B_EVSTART];
		next_clock_divider_select    = bus_i.wdata[10:8];
	end
	if (wr_at(bus_i, `ADCSEQ_A_INTEN))
		next_ie = bus_i.wdata[0];
	if (wr_at(bus_i, `ADCSEQ_A_SEL))
		next_shadow = '{chan: bus_i.wdata[4:0], ref_sel: bus_i.wdata[9:8]};
	if (wr_at(bus_i, `ADCSEQ_A_SAMP)) begin
		next_samp_dly = bus_i.wdata[7:0];
		next_samp_len = bus_i.wdata[15:8];
	end
	// flag clear by write one or result read; a completion below wins
	if (wr_at(bus_i, `ADCSEQ_A_FLAGS) && bus_i.wdata[`ADCSEQ_B_RDY])
		next_rdy = 1'b0;
	if (bus_i.rd && bus_i.addr == `ADCSEQ_A_RESULT)
		next_rdy = 1'b0;
	// read mux, data valid the cycle after the strobe
	if (bus_i.rd) begin
		case (bus_i.addr)
		`ADCSEQ_A_CTRL:   next_rdata = {21'h0, clock_divider_select, 5'h0, ev_en, free_run, enable};
		`ADCSEQ_A_CMD:    next_rdata = {31'h0, start_cmd};
		`ADCSEQ_A_FLAGS:  next_rdata = {31'h0, rdy};
		`ADCSEQ_A_INTEN:  next_rdata = {31'h0, ie};
		`ADCSEQ_A_SEL:    next_rdata = {22'h0, shadow.ref_sel, 3'h0, shadow.chan};
		`ADCSEQ_A_SAMP:   next_rdata = {16'h0, samp_len, samp_dly};
		`ADCSEQ_A_RESULT: next_rdata = {22'h0, result};
		`ADCSEQ_A_STATUS: next_rdata = {22'h0, cyc};
		default:          next_rdata = 32'h0;
		endcase
	end
	// sequencer
	case (state)
	adcseq_pkg::ADCSEQ_IDLE: begin
		next_div_cnt = 9'h000;
		next_active  = next_shadow;
		if (trig) begin
			next_start_cmd = 1'b1;
			next_state     = adcseq_pkg::ADCSEQ_ARM;
		end
	end
	adcseq_pkg::ADCSEQ_ARM: begin
		// half a prescale period passes here, then a full one in CONV before the first conversion clock
		next_div_cnt = tick ? 9'h000 : div_cnt + 9'h001;
		if (div_cnt == (div_last(clock_divider_select) >> 1)) begin
			next_state   = adcseq_pkg::ADCSEQ_CONV;
			next_div_cnt = 9'h000;
			next_cyc     = 10'h000;
		end
	end
	adcseq_pkg::ADCSEQ_CONV: begin
		next_div_cnt = tick ? 9'h000 : div_cnt + 9'h001;
		if (tick) begin
			next_cyc = cyc + 10'h001;
			// hold closes after the extended sampling window
			// the window spans 2 + delay + length ticks, so hold follows the last of them
			if (cyc == 10'(`ADCSEQ_HOLD_CYC) + 10'(samp_dly) + 10'(samp_len) - 10'h001)
				next_hold = 1'b1;
		end
		if (tick && cyc == total - 10'h002)
			next_active = shadow;
		if (done) begin
			next_result    = core_result_i;
			next_rdy       = 1'b1;
			next_ev_result = 1'b1;
			next_cyc       = 10'h000;
			if (free_run)
				next_state = adcseq_pkg::ADCSEQ_CONV;
			else begin
				next_start_cmd = 1'b0;
				next_state     = adcseq_pkg::ADCSEQ_IDLE;
			end
		end
	end
	default: next_state = adcseq_pkg::ADCSEQ_IDLE;
	endcase
	// disabling aborts all but a hold pulse or result capture due that cycle; no flag for that result
	if (!next_enable) begin
		next_state     = adcseq_pkg::ADCSEQ_IDLE;
		next_start_cmd = 1'b0;
		next_div_cnt   = 9'h000;
		next_cyc       = 10'h000;
		next_ev_result = 1'b0;
		next_rdy       = rdy && next_rdy;
	end
end

////////////////////////////////////////////////////////////////////////
// state registers
always_ff @(posedge clk_i) begin
	if (rst_i) begin
		enable      <= 1'b0;
		free_run    <= 1'b0;
		ev_en       <= 1'b0;
		start_cmd   <= 1'b0;
		rdy         <= 1'b0;
		ie          <= 1'b0;
		shadow      <= '0;
		active      <= '0;
		clock_divider_select       <= 3'h0;
		samp_dly    <= 8'h00;
		samp_len    <= 8'h00;
		result      <= 10'h000;
		state       <= adcseq_pkg::ADCSEQ_IDLE;
		div_cnt     <= 9'h000;
		cyc         <= 10'h000;
		ev_q        <= 1'b0;
		rdata_o     <= 32'h0;
		ev_result_o <= 1'b0;
		hold_o      <= 1'b0;
	end else begin
		enable      <= next_enable;
		free_run    <= next_free_run;
		ev_en       <= next_ev_en;
		start_cmd   <= next_start_cmd;
		rdy         <= next_rdy;
		ie          <= next_ie;
		shadow      <= next_shadow;
		active      <= next_active;
		clock_divider_select       <= next_clock_divider_select;
		samp_dly    <= next_samp_dly;
		samp_len    <= next_samp_len;
		result      <= next_result;
		state       <= next_state;
		div_cnt     <= next_div_cnt;
		cyc         <= next_cyc;
		ev_q        <= next_ev_q;
		rdata_o     <= next_rdata;
		ev_result_o <= next_ev_result;
		hold_o      <= next_hold;
	end
end

// outputs to the core and interrupt line
assign sel_o         = active;
assign conv_clk_en_o = tick;
assign irq_o         = rdy && ie && global_ie_i;

endmodule

// >>> adcseq_top_tb.sv
`timescale 1ns/1ns
`include "adcseq_consts.svh"
module adcseq_top_tb;
	logic                    clk_i = 1'b0;
	logic                    rst_i = 1'b1;
	adcseq_pkg::adcseq_bus_t bus_i = '0;
	logic                    ev_start_i = 1'b0;
	logic                    global_ie_i = 1'b0;
	logic [31:0]             rdata_o;
	logic                    irq_o, ev_result_o, conv_clk_en_o, hold_o;
	adcseq_pkg::adcseq_sel_t sel_o;
	logic [9:0]              core_result_i;
	int                      bad_count = 0;
	int                      compares = 0;

	// 10 MHz clock
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	adcseq_top i_adcseq_top (.clk_i, .rst_i, .bus_i, .rdata_o, .ev_start_i, .global_ie_i, .irq_o, .ev_result_o,
		.core_result_i, .sel_o, .conv_clk_en_o, .hold_o);
	adcseq_core_model i_adcseq_core_model (.clk_i, .sel_o, .hold_o, .core_result_o(core_result_i));

	////////////////////////////////////////////////////////////////
	// shared compare and bus cycles
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		bus_i.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		bus_i.rd <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	// follows one conversion: tick count, tick spacing, ticks before hold
	task automatic run(input int ticks, input int hold_at, input int gap);
		int t;
		int h;
		int last;
		int n;
		t = 0;
		h = -1;
		last = -1;
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
			if (hold_o === 1'b1) h = t;
			if (conv_clk_en_o === 1'b1) begin
				if (last >= 0) chk(n - last, gap);
				last = n;
				t++;
			end
		end while (ev_result_o !== 1'b1 && n < 20000);
		chk(t, ticks);
		chk(h, hold_at);
	endtask
	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#5000000;
		bad_count++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`ADCSEQ_A_CTRL, 32'h0);
		rd(4'h9, 32'h0);
		wr(`ADCSEQ_A_CMD, 32'h1);
		rd(`ADCSEQ_A_CMD, 32'h0);
		wr(`ADCSEQ_A_SEL, 32'h105);
		wr(`ADCSEQ_A_INTEN, 32'h1);
		wr(`ADCSEQ_A_CTRL, 32'h1);
		chk({25'h0, sel_o}, 32'h15);
		wr(`ADCSEQ_A_CMD, 32'h0);
		rd(`ADCSEQ_A_CMD, 32'h0);
		wr(`ADCSEQ_A_CMD, 32'h1);
		fork
			run(13, 2, 2);
			begin
				rd(`ADCSEQ_A_CMD, 32'h1);
				wr(`ADCSEQ_A_CMD, 32'h1);
				wr(`ADCSEQ_A_SEL, 32'h109);
				#1 chk({25'h0, sel_o}, 32'h15);
			end
		join
		chk({25'h0, sel_o}, 32'h25);
		chk({31'h0, irq_o}, 32'h0);
		rd(`ADCSEQ_A_CMD, 32'h0);
		rd(`ADCSEQ_A_FLAGS, 32'h1);
		global_ie_i <= 1'b1;
		@(posedge clk_i);
		#1 chk({31'h0, irq_o}, 32'h1);
		rd(`ADCSEQ_A_RESULT, 32'h2a5);
		chk({31'h0, irq_o}, 32'h0);
		// event start held high: only its rising edge may count
		wr(`ADCSEQ_A_SAMP, 32'h0201);
		wr(`ADCSEQ_A_CTRL, 32'h5);
		ev_start_i <= 1'b1;
		fork
			run(16, 5, 2);
			rd(`ADCSEQ_A_CMD, 32'h1);
		join
		repeat (100) @(posedge clk_i);
		rd(`ADCSEQ_A_CMD, 32'h0);
		ev_start_i <= 1'b0;
		chk({31'h0, irq_o}, 32'h1);
		wr(`ADCSEQ_A_FLAGS, 32'h1);
		#1 chk({31'h0, irq_o}, 32'h0);
		// free running at the next divider step, then abort by disable
		wr(`ADCSEQ_A_SAMP, 32'h0);
		wr(`ADCSEQ_A_CTRL, 32'h103);
		wr(`ADCSEQ_A_CMD, 32'h1);
		run(13, 2, 4);
		run(13, 2, 4);
		wr(`ADCSEQ_A_FLAGS, 32'h1);
		wr(`ADCSEQ_A_CTRL, 32'h0);
		rd(`ADCSEQ_A_CMD, 32'h0);
		repeat (200) @(posedge clk_i);
		rd(`ADCSEQ_A_FLAGS, 32'h0);
		give_verdict();
	end
endmodule
